// >>> sbd_core.sv
// Functional notes
// [RULE1] Prescaler divides bus clock by select+1
// [RULE2] Rate divider divides by two^(rate+1)
// [RULE3] Baud register readable and writable anytime
// [RULE4] Flag register read-only, unused bits zero
// [RULE5] Receive-full sets when transfer completes
// [RULE6] Receive-full clears: flag read, data read
// [RULE7] Transmit-empty clears: flag read, data write
// [RULE8] Data write dropped without armed flag read
// [RULE9] Interrupt when transmit-empty and its enable
// [RULE10] Transmit-empty sets on buffer-to-shifter move
// [RULE11] Idle: byte moves, flag back within two; code does so in master mode only, slave mode holds the byte
// [RULE12] Queued byte continues; else nothing moves
// [RULE13] Fault sets on select low, master, enabled
// [RULE14] Fault clears: flag read, control write
// [RULE15] Data read gives rx, write loads tx
// [RULE16] Master data write starts a transfer
// [RULE17] Software writes data only when empty
// [RULE18] Overrun keeps old byte, drops new
// [RULE19] Module disable aborts and clears buffers
// [RULE20] Receive/fault enable gates both flags
// [RULE21] Master select: zero slave, one master
// [RULE22] Bit period equals prescale times rate
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sbd_core
  import sbd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output sbd_ser_out_t ser_out,
  input wire logic miso,
  input wire logic ss_in_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] baud_reg; // Bit rate configuration
  logic [7:0] ctrl_reg; // First control register
  logic [7:0] txbuf_reg; // Transmit buffer
  logic [7:0] rxbuf_reg; // Receive buffer
  logic [7:0] shift_reg; // Shifter
  logic txe_reg; // Transmit-empty flag
  logic rxf_reg; // Receive-full flag
  logic master_fault_flag_reg; // Master fault flag
  logic txe_arm_reg; // Flag read saw transmit-empty
  logic rxf_arm_reg; // Flag read saw receive-full
  logic master_fault_flag_arm_reg; // Flag read saw fault
  logic tx_pend_reg; // Transmit buffer holds a byte
  sbd_state_t state_reg; // Shifter state
  logic [2:0] pre_cnt_reg; // Prescaler counter
  logic [7:0] rate_cnt_reg; // Rate divider counter
  logic [3:0] bit_cnt_reg; // Bits left
  logic sclk_reg; // Serial clock level
  logic [7:0] rdata_reg; // Read data hold
  logic [7:0] aw_addr_reg; // Latched write address
  logic aw_have_reg; // Write address held
  logic [7:0] w_data_reg; // Latched write data
  logic w_have_reg; // Write data held
  // Lane 0 strobe travels with its data beat, not with the later decode
  logic w_lane_reg;
  logic rx_bit_reg; // Input bit taken on rising serial clock
  logic bvalid_reg;
  logic rvalid_reg;
  logic rresp_err_reg;
  logic bresp_err_reg;

  // Decoded controls
  logic en, mst, tie, rie, fen, select_output_enable;
  assign en = ctrl_reg[SBD_C_EN];
  assign mst = ctrl_reg[SBD_C_MST]; // Zero slave, one master [RULE21]
  assign tie = ctrl_reg[SBD_C_TIE];
  assign rie = ctrl_reg[SBD_C_RIE];
  assign fen = ctrl_reg[SBD_C_FEN];
  assign select_output_enable = ctrl_reg[SBD_C_SELECT_OUTPUT_ENABLE];

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic wr_go; // Both halves present, response slot free
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_err_reg ? SBD_RESP_SLVERR : SBD_RESP_OKAY;

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[7:0];
      end else if (wr_go) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        // Only lane 0 carries data; a write with lane 0 off stores nothing
        w_data_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        w_lane_reg <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // Write decode strobes
  logic wr_baud, wr_ctrl, wr_data, wr_bad;
  assign wr_baud = wr_go && aw_addr_reg == SBD_OFF_BAUD;
  assign wr_ctrl = wr_go && aw_addr_reg == SBD_OFF_CTRL;
  assign wr_data = wr_go && aw_addr_reg == SBD_OFF_DATA;
  // Flag writes are accepted and ignored [RULE4]
  assign wr_bad = wr_go && !(wr_baud || wr_ctrl || wr_data || aw_addr_reg == SBD_OFF_FLAG);

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_err_reg <= 1'b0;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_err_reg <= wr_bad;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Baud and control registers; writable any time [RULE3]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_reg <= SBD_BAUD_RST;
      ctrl_reg <= SBD_CTRL_RST;
    end else begin
      if (wr_baud && w_lane_reg) begin
        baud_reg <= w_data_reg & 8'h77;
      end
      if (wr_ctrl && w_lane_reg) begin
        ctrl_reg <= w_data_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic rd_go, rd_flag, rd_data;
  assign s_axi_arready = !rvalid_reg;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_flag = rd_go && s_axi_araddr[7:0] == SBD_OFF_FLAG;
  assign rd_data = rd_go && s_axi_araddr[7:0] == SBD_OFF_DATA;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = {24'h00_0000, rdata_reg};
  assign s_axi_rresp = rresp_err_reg ? SBD_RESP_SLVERR : SBD_RESP_OKAY;

  // Flag value; unused bits read zero [RULE4]
  logic [7:0] flag_val;
  always_comb begin
    flag_val = 8'h00;
    flag_val[SBD_RXF_BIT] = rxf_reg;
    flag_val[SBD_TXE_BIT] = txe_reg;
    flag_val[SBD_MASTER_FAULT_FLAG_BIT] = master_fault_flag_reg;
  end

  // Read data captured in the accept cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rresp_err_reg <= 1'b0;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rresp_err_reg <= 1'b0;
      case (s_axi_araddr[7:0])
        SBD_OFF_BAUD: rdata_reg <= baud_reg;
        SBD_OFF_FLAG: rdata_reg <= flag_val;
        SBD_OFF_DATA: rdata_reg <= rxbuf_reg; // [RULE15]
        SBD_OFF_CTRL: rdata_reg <= ctrl_reg;
        default: begin
          rdata_reg <= 8'h00;
          rresp_err_reg <= 1'b1;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bit rate generator
  // ----------------------------------------------------------------
  logic [2:0] pre_sel, rate_sel;
  logic pre_tick, half_tick;
  logic [7:0] rate_half; // Half of rate divisor, minus one
  assign pre_sel = baud_reg[SBD_PRE_LSB +: 3];
  assign rate_sel = baud_reg[SBD_RATE_LSB +: 3];
  assign pre_tick = pre_cnt_reg == pre_sel; // Divide by select+1 [RULE1]
  // Toggle every 2^rate prescaled ticks: period 2^(rate+1) [RULE2]
  assign rate_half = 8'((9'h001 << rate_sel) - 9'h001);
  assign half_tick = pre_tick && rate_cnt_reg == rate_half;

  // Counters run only while shifting so each transfer starts aligned
  always_ff @(posedge aclk) begin
    if (!aresetn || !en || state_reg != SBD_SHIFT) begin
      pre_cnt_reg <= 3'h0;
      rate_cnt_reg <= 8'h00;
    end else if (pre_tick) begin
      pre_cnt_reg <= 3'h0;
      // Full bit period = prescale * rate divisors [RULE22]
      rate_cnt_reg <= half_tick ? 8'h00 : rate_cnt_reg + 8'h01;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Shifter (mode 0, MSB first)
  // ----------------------------------------------------------------
  logic load_now, done;
  // Byte moves when shifter idle or finishing [RULE11] [RULE12]
  assign done = state_reg == SBD_SHIFT && half_tick && sclk_reg && bit_cnt_reg == 4'h1;
  assign load_now = tx_pend_reg && mst && (state_reg == SBD_IDLE || done);

  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      // Disable aborts transfer and resets state [RULE19]
      state_reg <= SBD_IDLE;
      sclk_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= SBD_DATA_RST;
    end else begin
      case (state_reg)
        SBD_IDLE: begin
          if (load_now) begin
            shift_reg <= txbuf_reg; // [RULE16]
            bit_cnt_reg <= SBD_BITS;
            state_reg <= SBD_SHIFT;
          end
        end
        SBD_SHIFT: begin
          if (half_tick) begin
            sclk_reg <= !sclk_reg;
            if (sclk_reg) begin
              // Falling edge: shift in sampled bit
              bit_cnt_reg <= bit_cnt_reg - 4'h1;
              if (done && load_now) begin
                shift_reg <= txbuf_reg; // Continue with queued byte [RULE12]
                bit_cnt_reg <= SBD_BITS;
              end else if (done) begin
                state_reg <= SBD_IDLE;
              end else begin
                shift_reg <= {shift_reg[6:0], rx_bit_reg};
              end
            end
          end
        end
        default: state_reg <= SBD_IDLE;
      endcase
    end
  end

  // Sampled input bit on rising serial clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_bit_reg <= 1'b0;
    end else if (state_reg == SBD_SHIFT && half_tick && !sclk_reg) begin
      rx_bit_reg <= miso;
    end
  end

  // Automatic select output only with fault function and output enable
  logic ss_out_n;
  assign ss_out_n = !(mst && fen && select_output_enable && state_reg == SBD_SHIFT);
  // One driver for the whole pin group
  assign ser_out = '{sclk: sclk_reg, mosi: shift_reg[7], ss_n: ss_out_n};

  // ----------------------------------------------------------------
  // Transmit buffer and transmit-empty flag
  // ----------------------------------------------------------------
  logic tx_accept;
  // Write kept only after an armed flag read [RULE8]
  assign tx_accept = wr_data && w_lane_reg && txe_arm_reg && txe_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      txe_reg <= 1'b1; // [RULE19]
      tx_pend_reg <= 1'b0;
      txbuf_reg <= SBD_DATA_RST;
      txe_arm_reg <= 1'b0;
    end else begin
      if (tx_accept) begin
        txbuf_reg <= w_data_reg; // [RULE15]
        tx_pend_reg <= 1'b1;
        txe_reg <= 1'b0; // [RULE7]
        txe_arm_reg <= 1'b0;
      end else if (load_now) begin
        tx_pend_reg <= 1'b0;
        txe_reg <= 1'b1; // Set on move into shifter [RULE10]
      end
      if (rd_flag && txe_reg) begin
        txe_arm_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer and receive-full flag
  // ----------------------------------------------------------------
  logic [7:0] rx_byte;
  assign rx_byte = {shift_reg[6:0], rx_bit_reg};

  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      rxf_reg <= 1'b0; // [RULE19]
      rxbuf_reg <= SBD_DATA_RST;
      rxf_arm_reg <= 1'b0;
    end else begin
      if (done) begin
        rxf_reg <= 1'b1; // [RULE5]
        // Overrun: keep the unread byte [RULE18]
        if (!rxf_reg) begin
          rxbuf_reg <= rx_byte;
        end
      end else if (rd_data && rxf_arm_reg) begin
        rxf_reg <= 1'b0; // Set wins over clear [RULE6]
      end
      if (rd_flag && rxf_reg) begin
        rxf_arm_reg <= 1'b1;
      end else if (rd_data) begin
        rxf_arm_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Master fault detection
  // ----------------------------------------------------------------
  logic fault_cond;
  assign fault_cond = mst && fen && !select_output_enable && !ss_in_n; // [RULE13]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_fault_flag_reg <= 1'b0;
      master_fault_flag_arm_reg <= 1'b0;
    end else begin
      if (en && fault_cond) begin
        master_fault_flag_reg <= 1'b1;
      end else if (wr_ctrl && master_fault_flag_arm_reg) begin
        master_fault_flag_reg <= 1'b0; // [RULE14]
      end
      if (rd_flag && master_fault_flag_reg) begin
        master_fault_flag_arm_reg <= 1'b1;
      end else if (wr_ctrl) begin
        master_fault_flag_arm_reg <= 1'b0;
      end
    end
  end

  // Interrupt request [RULE9] [RULE20]
  assign irq = (tie && txe_reg) || (rie && (rxf_reg || master_fault_flag_reg));

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_tx_dropped: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
    (wr_data && !txe_arm_reg) |=> $stable(txbuf_reg))
    else $error("Unarmed data write changed tx buffer");
  a_txe_refill: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE11]
    (tx_accept && mst && state_reg == SBD_IDLE) |-> ##[1:2] txe_reg)
    else $error("Transmit-empty not back within two cycles");
  a_rxf_on_done: assert property (@(posedge aclk) disable iff (!aresetn || !en) // [RULE5]
    done |=> rxf_reg)
    else $error("Receive-full not set at transfer end");
  a_rx_overrun: assert property (@(posedge aclk) disable iff (!aresetn || !en) // [RULE18]
    (done && rxf_reg) |=> $stable(rxbuf_reg))
    else $error("Overrun overwrote receive buffer");
  a_master_fault_flag_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
    (!master_fault_flag_reg && !(mst && fen && !select_output_enable)) |=> !master_fault_flag_reg)
    else $error("Fault set outside master fault mode");
  a_irq_tx: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE9]
    (tie && txe_reg) |-> irq)
    else $error("Missing transmit interrupt");
  a_flag_ro: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
    (wr_go && aw_addr_reg == SBD_OFF_FLAG && !done && !load_now && !fault_cond)
      |=> $stable(flag_val))
    else $error("Flag write changed flags");
  a_disable_clr: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE19]
    !en |=> (txe_reg && !rxf_reg && state_reg == SBD_IDLE))
    else $error("Disable did not clear state");
  c_xfer_done: cover property (@(posedge aclk) disable iff (!aresetn) done);
  c_back2back: cover property (@(posedge aclk) disable iff (!aresetn) done && load_now);
  c_fault: cover property (@(posedge aclk) disable iff (!aresetn) $rose(master_fault_flag_reg));

endmodule
`default_nettype wire

// >>> sbd_pkg.sv
package sbd_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SBD_OFF_BAUD = 8'h00; // Bit rate configuration
  localparam logic [7:0] SBD_OFF_FLAG = 8'h04; // Flag register
  localparam logic [7:0] SBD_OFF_DATA = 8'h08; // Serial data buffer
  localparam logic [7:0] SBD_OFF_CTRL = 8'h0C; // First control register

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SBD_PRE_LSB = 4; // prescale_select [6:4]
  localparam int SBD_RATE_LSB = 0; // rate_select [2:0]
  localparam int SBD_RXF_BIT = 7; // receive_full_flag
  localparam int SBD_TXE_BIT = 5; // transmit_empty_flag
  localparam int SBD_MASTER_FAULT_FLAG_BIT = 4; // master_fault_flag
  localparam int SBD_C_TIE = 5; // transmit_interrupt_enable
  localparam int SBD_C_RIE = 7; // receive_fault_interrupt_enable
  localparam int SBD_C_EN = 6; // module_enable
  localparam int SBD_C_MST = 4; // master_select
  localparam int SBD_C_SELECT_OUTPUT_ENABLE = 1; // select_output_enable
  localparam int SBD_C_FEN = 2; // fault_function_enable

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] SBD_BAUD_RST = 8'h00;
  localparam logic [7:0] SBD_CTRL_RST = 8'h00;
  localparam logic [7:0] SBD_DATA_RST = 8'h00;
  localparam logic [3:0] SBD_BITS = 4'h8; // Bits per transfer
  localparam logic [1:0] SBD_RESP_OKAY = 2'b00;
  localparam logic [1:0] SBD_RESP_SLVERR = 2'b10;

  // Shifter states, one-hot
  typedef enum logic [1:0] {
    SBD_IDLE = 2'b01,
    SBD_SHIFT = 2'b10
  } sbd_state_t;

  // Serial pins grouped
  typedef struct packed {
    logic sclk; // serial_clock_pin
    logic mosi;
    logic ss_n;
  } sbd_ser_out_t;

endpackage

// >>> sbd_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Far-side serial peripheral: mode 0, MSB first
// ----------------------------------------------------------------
module sbd_slave_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic [7:0] tx_byte,
  output var logic miso,
  output var logic [7:0] rx_byte,
  output var int nframes
);
  logic [7:0] sh = 8'h00; // Outgoing shifter
  logic [3:0] cnt = 4'h0; // Bits sampled this frame
  logic last = 1'b0; // Last bit put on the line
  initial begin
    rx_byte = 8'h00;
    nframes = 0;
  end
  // Odd frames send the inverted byte so an overrun shows
  function automatic logic [7:0] pick(input int n);
    return tx_byte ^ {8{n[0]}};
  endfunction
  // Selection loads the first byte and restarts the count
  always @(negedge ss_n) begin
    sh = pick(nframes);
    cnt = 4'h0;
  end
  // Sample on the rising edge
  always @(posedge sclk) begin
    rx_byte = {rx_byte[6:0], mosi};
    cnt = cnt + 4'h1;
    if (cnt == 4'h8) nframes = nframes + 1;
  end
  // Shift on the falling edge, reload after a whole byte
  always @(negedge sclk) begin
    if (cnt == 4'h8) begin
      sh = pick(nframes);
      cnt = 4'h0;
    end else begin
      sh = {sh[6:0], 1'b0};
    end
  end
  // Deselected: inverse of the last bit, so no stale value passes
  always @(ss_n or sh) begin
    if (!ss_n) begin
      miso = sh[7];
      last = sh[7];
    end else begin
      miso = ~last;
    end
  end
endmodule
`default_nettype wire

// >>> sbd_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sbd_core_tb;
  import sbd_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, miso;
  logic ss_in_n = 1'b1; // Fault input, idle high
  logic [1:0] bresp, rresp;
  logic [7:0] slave_tx = 8'h00, slave_rx;
  sbd_ser_out_t ser_out;
  int nframes, miscompares = 0, n_compared = 0;
  int cyc = 0, last_rise = 0, per = 0, nrise = 0; // Serial clock monitor
  logic sck_q = 1'b0;

  always #5 aclk = ~aclk;

  sbd_core i_sbd_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ser_out(ser_out), .miso(miso), .ss_in_n(ss_in_n), .irq(irq));
  sbd_slave_model i_sbd_slave_model (.sclk(ser_out.sclk), .mosi(ser_out.mosi),
    .ss_n(ser_out.ss_n), .tx_byte(slave_tx), .miso(miso), .rx_byte(slave_rx),
    .nframes(nframes));

  // Period between serial clock rises, in bus cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    sck_q <= ser_out.sclk;
    if (ser_out.sclk === 1'b1 && sck_q === 1'b0) begin
      per <= cyc - last_rise;
      last_rise <= cyc;
      nrise <= nrise + 1;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // A wait that ran out counts as a mismatch
  task automatic give_up;
    miscompares++;
    conclude();
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] er = SBD_RESP_OKAY);
    int n;
    @(posedge aclk);
    awaddr <= {24'h00_0000, a};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    if (bvalid !== 1'b1) give_up();
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    if (rvalid !== 1'b1) give_up();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(what, d, exp);
    check("rresp", {30'h0, r}, 32'h0000_0000);
  endtask
  // Poll the flag register until all bits of m are set
  task automatic wait_flag(input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      rd(SBD_OFF_FLAG, d, r);
      n++;
    end while ((d & m) !== m && n < 2000);
    if ((d & m) !== m) give_up();
  endtask
  task automatic pulse_ss;
    @(posedge aclk);
    ss_in_n <= 1'b0;
    repeat (3) @(posedge aclk);
    ss_in_n <= 1'b1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios (ctrl 8'h56: enable, master, fault function, select out)
  // ----------------------------------------------------------------
  task automatic t_unarmed;
    wr(SBD_OFF_CTRL, 8'h56);
    wr(SBD_OFF_DATA, 8'hC3);
    repeat (64) @(posedge aclk);
    check("rises unarmed", 32'(nrise), 32'h0000_0000);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rdc(SBD_OFF_FLAG, 32'h0000_0020, "flag reset");
    rdc(SBD_OFF_DATA, 32'h0000_0000, "data reset");
    wr(SBD_OFF_FLAG, 8'hFF);
    rdc(SBD_OFF_FLAG, 32'h0000_0020, "flag after write");
    wr(SBD_OFF_BAUD, 8'h73);
    rdc(SBD_OFF_BAUD, 32'h0000_0073, "baud");
    rd(8'h10, d, r);
    check("unmapped rresp", {30'h0, r}, {30'h0, SBD_RESP_SLVERR});
    wr(8'h10, 8'h00, SBD_RESP_SLVERR);
  endtask
  // Every divider extreme, one full byte each way
  task automatic t_xfers;
    logic [2:0] pre [4] = '{3'h0, 3'h7, 3'h1, 3'h0};
    logic [2:0] rate [4] = '{3'h0, 3'h0, 3'h2, 3'h7};
    logic [7:0] exp_rx;
    for (int i = 0; i < 4; i++) begin
      slave_tx <= 8'h3C + 8'(i);
      wr(SBD_OFF_BAUD, {1'b0, pre[i], 1'b0, rate[i]});
      rdc(SBD_OFF_FLAG, 32'h0000_0020, "flag arm");
      exp_rx = (8'h3C + 8'(i)) ^ {8{nframes[0]}};
      wr(SBD_OFF_DATA, 8'hA5 ^ 8'(i));
      rdc(SBD_OFF_FLAG, 32'h0000_0020, "tx empty again");
      wait_flag(32'h0000_0080);
      rdc(SBD_OFF_DATA, {24'h00_0000, exp_rx}, "rx data");
      check("slave rx", {24'h00_0000, slave_rx}, {24'h00_0000, 8'hA5 ^ 8'(i)});
      check("period", 32'(per), 32'((pre[i] + 1) << (rate[i] + 1)));
      rdc(SBD_OFF_FLAG, 32'h0000_0020, "rx full cleared");
    end
  endtask
  // Queue a second byte and leave the first unread
  task automatic t_overrun;
    int f0;
    int n;
    logic [7:0] first;
    wr(SBD_OFF_BAUD, 8'h03);
    slave_tx <= 8'h5A;
    rdc(SBD_OFF_FLAG, 32'h0000_0020, "flag arm");
    f0 = nframes;
    first = 8'h5A ^ {8{f0[0]}};
    wr(SBD_OFF_DATA, 8'h11);
    rdc(SBD_OFF_FLAG, 32'h0000_0020, "first moved");
    wr(SBD_OFF_DATA, 8'h22);
    rdc(SBD_OFF_FLAG, 32'h0000_0000, "queued");
    wait_flag(32'h0000_0020);
    n = 0;
    while (nframes < f0 + 2 && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    if (nframes < f0 + 2) give_up();
    repeat (40) @(posedge aclk);
    rdc(SBD_OFF_DATA, {24'h00_0000, first}, "old byte kept");
    check("second sent", {24'h00_0000, slave_rx}, 32'h0000_0022);
  endtask
  task automatic t_fault;
    wr(SBD_OFF_CTRL, 8'hD4);
    pulse_ss();
    check("irq fault", {31'h0, irq}, 32'h0000_0001);
    wr(SBD_OFF_CTRL, 8'h54);
    check("irq gated", {31'h0, irq}, 32'h0000_0000);
    rdc(SBD_OFF_FLAG, 32'h0000_0030, "fault held");
    wr(SBD_OFF_CTRL, 8'h54);
    rdc(SBD_OFF_FLAG, 32'h0000_0020, "fault cleared");
    wr(SBD_OFF_CTRL, 8'h56);
    pulse_ss();
    rdc(SBD_OFF_FLAG, 32'h0000_0020, "no fault select_output_enable");
    wr(SBD_OFF_CTRL, 8'h44);
    pulse_ss();
    rdc(SBD_OFF_FLAG, 32'h0000_0020, "no fault slave");
    check("irq no tie", {31'h0, irq}, 32'h0000_0000);
    wr(SBD_OFF_CTRL, 8'h66);
    check("irq tx empty", {31'h0, irq}, 32'h0000_0001);
  endtask
  // Slave mode holds the byte; disabling mid-transfer aborts it
  task automatic t_disable;
    int n0;
    n0 = nrise;
    wr(SBD_OFF_DATA, 8'h99);
    repeat (64) @(posedge aclk);
    check("rises slave", 32'(nrise), 32'(n0));
    wr(SBD_OFF_CTRL, 8'h00);
    rdc(SBD_OFF_FLAG, 32'h0000_0020, "disabled flag");
    wr(SBD_OFF_CTRL, 8'h56);
    wr(SBD_OFF_BAUD, 8'h07);
    rdc(SBD_OFF_FLAG, 32'h0000_0020, "flag arm");
    wr(SBD_OFF_DATA, 8'h77);
    repeat (300) @(posedge aclk);
    wr(SBD_OFF_CTRL, 8'h16);
    n0 = nrise;
    repeat (600) @(posedge aclk);
    wr(SBD_OFF_CTRL, 8'h56);
    rdc(SBD_OFF_FLAG, 32'h0000_0020, "aborted flag");
    rdc(SBD_OFF_DATA, 32'h0000_0000, "buffer cleared");
    check("rises aborted", 32'(nrise), 32'(n0));
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_unarmed();
    t_regs();
    t_xfers();
    t_overrun();
    t_fault();
    t_disable();
    conclude();
  end
endmodule
`default_nettype wire
